// file: inc/bsc_pkg.sv
// Notes on behaviour
// - init done only after config done
// - config done flags finished autoconfig, reset zero
// - verify two's-complement sum over last 128 bytes
// - checksum bit one on pass, resets one
// - pixel size code selects 3, 2.25, 2 bytes
// - all RGB inputs become 24-bit RGB888
// - YCbCr and compressed pass through unconverted
// - independent mode: per-port pixel size copy
// - TDM enable serializes parallel audio onto primary
// - audio source bit: 0 off, 1 pins
// - continuous clock skips clock-lane initialization
// - reload request clears when reload finished
package bsc_pkg;
    localparam logic [7:0] BSC_ADDR_STATUS = 8'h50;
    localparam logic [7:0] BSC_ADDR_CONFIG = 8'h54;
    localparam logic [7:0] BSC_ADDR_CTRL   = 8'h58;
    localparam logic [7:0] BSC_ADDR_IRQ_ST = 8'h5C;
    localparam logic [7:0] BSC_ADDR_IRQ_MK = 8'h60;
    localparam logic [7:0] BSC_ADDR_FMT    = 8'h64;
    localparam int BSC_ST_INIT_DONE = 4;
    localparam int BSC_ST_CFG_DONE  = 2;
    localparam int BSC_ST_CKSUM     = 1;
    localparam int BSC_CF_BPP_LO    = 4;
    localparam int BSC_CF_TDM       = 2;
    localparam int BSC_CF_AUDIO_SRC = 1;
    localparam int BSC_CF_AUX       = 0;
    localparam int BSC_CT_RELOAD    = 1;
    localparam int BSC_CT_CONT_CLK  = 7;
    localparam int BSC_CT_PORT_SEL  = 5;
    localparam int BSC_CT_INDEP     = 0;
    localparam logic [7:0] BSC_STATUS_RST = 8'h02;
    localparam logic [7:0] BSC_CONFIG_RST = 8'h02;
    localparam logic [7:0] BSC_CONFIG_WMASK = 8'h37;
    localparam logic [7:0] BSC_CTRL_WMASK = 8'hA3;
    localparam logic [2:0] BSC_IRQ_WMASK = 3'h7;
    localparam int BSC_NVM_BYTES = 128;
    localparam int BSC_NVM_CFG_BYTES = 16;
    localparam logic [1:0] BSC_BPP_3    = 2'h0;
    localparam logic [1:0] BSC_BPP_2P25 = 2'h1;
    localparam logic [1:0] BSC_BPP_2    = 2'h2;
    localparam logic [2:0] BSC_FMT_RGB888 = 3'h0;
    localparam logic [2:0] BSC_FMT_RGB666L = 3'h1;
    localparam logic [2:0] BSC_FMT_RGB666P = 3'h2;
    localparam logic [2:0] BSC_FMT_RGB565 = 3'h3;
    localparam logic [2:0] BSC_FMT_YCBCR  = 3'h4;
    localparam logic [2:0] BSC_FMT_COMP   = 3'h5;
    typedef enum logic [2:0] {BSC_S_IDLE, BSC_S_READ, BSC_S_CHECK, BSC_S_INIT,
                              BSC_S_DONE} bsc_state_t;
endpackage

// file: rtl/bsc_pixel_conv.sv
`timescale 1ns/10ps
module bsc_pixel_conv
    import bsc_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // input pixel
    input  wire logic        in_valid,
    input  wire logic [2:0]  in_format,
    input  wire logic [23:0] in_data,
    // output pixel
    output logic             out_valid,
    output logic [23:0]      out_data
);
    // rgb expansion replicates msbs so full scale stays full scale
    function automatic logic [7:0] bsc_exp6(input logic [5:0] v);
        return {v, v[5:4]};
    endfunction
    function automatic logic [7:0] bsc_exp5(input logic [4:0] v);
        return {v, v[4:2]};
    endfunction
    wire logic [23:0] rgb666_px = {bsc_exp6(in_data[17:12]), bsc_exp6(in_data[11:6]),
                                   bsc_exp6(in_data[5:0])};
    wire logic [23:0] rgb565_px = {bsc_exp5(in_data[15:11]), bsc_exp6(in_data[10:5]),
                                   bsc_exp5(in_data[4:0])};
    wire logic        is_666    = (in_format == BSC_FMT_RGB666L) ||
                                  (in_format == BSC_FMT_RGB666P);
    wire logic        is_565    = (in_format == BSC_FMT_RGB565);
    // ycbcr and compressed fall to the raw path
    wire logic [23:0] conv_px   = is_666 ? rgb666_px :
                                  is_565 ? rgb565_px : in_data;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_valid <= 1'b0;
            out_data  <= 24'h000000;
        end else begin
            out_valid <= in_valid;
            out_data  <= conv_px;
        end
    end
    AST_PASS_THROUGH: assert property (@(posedge ref_clk) disable iff (sys_rst)
        in_valid && (in_format == BSC_FMT_YCBCR || in_format == BSC_FMT_COMP)
        |=> out_data == $past(in_data)) else $error("ycbcr pixel was altered");
    AST_RGB565_EXP: assert property (@(posedge ref_clk) disable iff (sys_rst)
        in_valid && is_565 |=> out_data[23:19] == $past(in_data[15:11]) &&
        out_data[7:3] == $past(in_data[4:0])) else $error("rgb565 expansion wrong");
endmodule

// file: rtl/bsc_regs.sv
`timescale 1ns/10ps
module bsc_regs
    import bsc_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    // non-volatile memory read port
    output logic             nvm_rd,
    output logic [6:0]       nvm_addr,
    input  wire logic [7:0]  nvm_data,
    // video
    input  wire logic        pix_valid,
    input  wire logic [2:0]  pix_format,
    input  wire logic [23:0] pix_data,
    output logic             pix_out_valid,
    output logic [23:0]      pix_out_data,
    output logic [1:0]       input_pixel_byte_count,
    output logic [1:0]       input_pixel_byte_count_port1,
    output logic             clk_lane_hs_bypass,
    // audio
    input  wire logic [3:0]  audio_par_data,
    output logic             primary_audio_data_pin,
    output logic             audio_enable,
    output logic             aux_audio_enable,
    // interrupt
    output logic             irq
);
    bsc_state_t  state_reg, state_next;
    logic [7:0]  config_reg, config_p1_reg, ctrl_reg;
    logic        cfg_done_reg, init_done_reg, cksum_ok_reg;
    logic [7:0]  sum_reg;
    logic [6:0]  idx_reg;
    logic        nvm_rd_reg;
    logic [7:0]  rdata_reg;
    logic [2:0]  irq_st_reg, irq_mk_reg;
    logic        irq_reg;
    logic [1:0]  tdm_slot_reg;
    logic        aud_reg;

    // port1 copy is written when independent mode and port select both set
    wire logic indep   = ctrl_reg[BSC_CT_INDEP];
    wire logic sel_p1  = indep && ctrl_reg[BSC_CT_PORT_SEL];
    wire logic wr_stat = reg_wr && (reg_addr == BSC_ADDR_STATUS);
    wire logic wr_cfg  = reg_wr && (reg_addr == BSC_ADDR_CONFIG);
    wire logic wr_ctl  = reg_wr && (reg_addr == BSC_ADDR_CTRL);
    wire logic wr_ist  = reg_wr && (reg_addr == BSC_ADDR_IRQ_ST);
    wire logic wr_imk  = reg_wr && (reg_addr == BSC_ADDR_IRQ_MK);
    wire logic [7:0] cfg_view = sel_p1 ? config_p1_reg : config_reg;
    wire logic [7:0] status_view = {3'h0, init_done_reg, 1'b0, cfg_done_reg,
                                    cksum_ok_reg, 1'b0};
    wire logic [7:0] rd_mux;
    wire logic reload_req = wr_ctl && reg_wdata[BSC_CT_RELOAD];
    wire logic [7:0] sum_after = sum_reg + nvm_data;
    // the last 128 bytes must sum to zero modulo 256
    wire logic cksum_pass = (sum_after == 8'h00);
    wire logic last_byte  = (idx_reg == 7'(BSC_NVM_BYTES - 1));
    // events: cfg done, init done, checksum fail
    wire logic ev_cfg  = (state_reg == BSC_S_CHECK);
    wire logic ev_init = (state_reg == BSC_S_INIT);
    wire logic ev_fail = (state_reg == BSC_S_READ) && last_byte && !cksum_pass;
    wire logic [2:0] ev_vec = {ev_fail, ev_init, ev_cfg};
    wire logic [2:0] irq_st_next = ev_vec | (irq_st_reg & ~({3{wr_ist}} & reg_wdata[2:0]));

    assign rd_mux = (reg_addr == BSC_ADDR_STATUS) ? status_view :
                    (reg_addr == BSC_ADDR_CONFIG) ? (cfg_view & BSC_CONFIG_WMASK) :
                    (reg_addr == BSC_ADDR_CTRL)   ? ctrl_reg :
                    (reg_addr == BSC_ADDR_IRQ_ST) ? {5'h00, irq_st_reg} :
                    (reg_addr == BSC_ADDR_IRQ_MK) ? {5'h00, irq_mk_reg} : 8'h00;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            BSC_S_IDLE:  if (reload_req) state_next = BSC_S_READ;
            BSC_S_READ:  if (last_byte) state_next = BSC_S_CHECK;
            BSC_S_CHECK: state_next = BSC_S_INIT;
            BSC_S_INIT:  state_next = BSC_S_DONE;
            BSC_S_DONE:  state_next = BSC_S_IDLE;
            default:     state_next = BSC_S_IDLE;
        endcase
    end

    // reload starts at power-up release as well as on request
    logic boot_reg;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= BSC_S_IDLE;
            boot_reg  <= 1'b1;
        end else begin
            boot_reg  <= 1'b0;
            state_reg <= (boot_reg && state_reg == BSC_S_IDLE) ? BSC_S_READ : state_next;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            idx_reg    <= 7'h00;
            sum_reg    <= 8'h00;
            nvm_rd_reg <= 1'b0;
        end else if (state_reg == BSC_S_READ) begin
            idx_reg    <= last_byte ? 7'h00 : idx_reg + 7'h01;
            sum_reg    <= last_byte ? 8'h00 : sum_after;
            nvm_rd_reg <= !last_byte;
        end else begin
            idx_reg    <= 7'h00;
            sum_reg    <= 8'h00;
            nvm_rd_reg <= (state_next == BSC_S_READ) ||
                          (boot_reg && state_reg == BSC_S_IDLE);
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_done_reg  <= 1'b0;
            init_done_reg <= 1'b0;
            cksum_ok_reg  <= BSC_STATUS_RST[BSC_ST_CKSUM];
        end else begin
            if (state_reg == BSC_S_READ && idx_reg == 7'h00) begin
                cfg_done_reg  <= 1'b0;
                init_done_reg <= 1'b0;
            end
            if (ev_cfg) cfg_done_reg <= 1'b1;
            if (ev_init && cfg_done_reg) init_done_reg <= 1'b1;
            if (state_reg == BSC_S_READ && last_byte) cksum_ok_reg <= cksum_pass;
        end
    end

    // config writes touch only writable fields; reserved stay zero
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            config_reg    <= BSC_CONFIG_RST;
            config_p1_reg <= BSC_CONFIG_RST;
        end else if (wr_cfg) begin
            if (sel_p1) config_p1_reg <= reg_wdata & BSC_CONFIG_WMASK;
            else config_reg <= reg_wdata & BSC_CONFIG_WMASK;
        end
    end

    // reload bit self-clears as the sequence ends
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg <= 8'h00;
        end else if (wr_ctl) begin
            ctrl_reg <= reg_wdata & BSC_CTRL_WMASK;
        end else if (state_reg == BSC_S_DONE) begin
            ctrl_reg[BSC_CT_RELOAD] <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_st_reg <= 3'h0;
            irq_mk_reg <= 3'h0;
            irq_reg    <= 1'b0;
            rdata_reg  <= 8'h00;
        end else begin
            irq_st_reg <= irq_st_next;
            if (wr_imk) irq_mk_reg <= reg_wdata[2:0] & BSC_IRQ_WMASK;
            // a set mask bit hides its event; new mask applies at once
            irq_reg    <= |(irq_st_next & ~(wr_imk ? reg_wdata[2:0] : irq_mk_reg));
            rdata_reg  <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // audio: tdm rotates through four inputs, else lane 0 only
    wire logic aud_src = config_reg[BSC_CF_AUDIO_SRC];
    wire logic tdm_en  = config_reg[BSC_CF_TDM];
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tdm_slot_reg <= 2'h0;
            aud_reg      <= 1'b0;
        end else begin
            tdm_slot_reg <= tdm_en ? tdm_slot_reg + 2'h1 : 2'h0;
            aud_reg      <= !aud_src ? 1'b0 :
                            tdm_en ? audio_par_data[tdm_slot_reg] : audio_par_data[0];
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            input_pixel_byte_count       <= BSC_BPP_3;
            input_pixel_byte_count_port1 <= BSC_BPP_3;
            clk_lane_hs_bypass           <= 1'b0;
            audio_enable                 <= 1'b0;
            aux_audio_enable             <= 1'b0;
        end else begin
            input_pixel_byte_count       <= config_reg[BSC_CF_BPP_LO +: 2];
            input_pixel_byte_count_port1 <= indep ? config_p1_reg[BSC_CF_BPP_LO +: 2]
                                                  : config_reg[BSC_CF_BPP_LO +: 2];
            clk_lane_hs_bypass           <= ctrl_reg[BSC_CT_CONT_CLK];
            audio_enable                 <= aud_src;
            aux_audio_enable             <= config_reg[BSC_CF_AUX];
        end
    end

    bsc_pixel_conv u_conv (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .in_valid  (pix_valid),
        .in_format (pix_format),
        .in_data   (pix_data),
        .out_valid (pix_out_valid),
        .out_data  (pix_out_data)
    );

    assign reg_rdata              = rdata_reg;
    assign nvm_rd                 = nvm_rd_reg;
    assign nvm_addr               = idx_reg;
    assign primary_audio_data_pin = aud_reg;
    assign irq                    = irq_reg;

    AST_INIT_AFTER_CFG: assert property (@(posedge ref_clk) disable iff (sys_rst)
        init_done_reg |-> cfg_done_reg) else $error("init done without cfg done");
    AST_CFG_DONE_SET: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ev_cfg |=> cfg_done_reg) else $error("cfg done not set");
    AST_CKSUM_RESULT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_reg == BSC_S_READ && last_byte |=> cksum_ok_reg == $past(cksum_pass))
        else $error("checksum status wrong");
    AST_READ_LEN: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(state_reg == BSC_S_READ) |-> (state_reg == BSC_S_READ) [*8])
        else $error("nvm read too short");
    AST_BPP_OUT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ##1 input_pixel_byte_count == $past(config_reg[5:4]))
        else $error("pixel size output stale");
    AST_RELOAD_CLR: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_reg == BSC_S_DONE && !wr_ctl |=> !ctrl_reg[BSC_CT_RELOAD])
        else $error("reload bit not cleared");
    AST_AUDIO_OFF: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !aud_src |=> !primary_audio_data_pin) else $error("audio not muted");
    AST_AUX_EN: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ##1 aux_audio_enable == $past(config_reg[0])) else $error("aux enable stale");
    AST_STATUS_RO: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_stat |=> $stable(cksum_ok_reg) || $past(state_reg == BSC_S_READ))
        else $error("status written by software");
    AST_RSVD_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (config_reg & ~BSC_CONFIG_WMASK) == 8'h00) else $error("reserved bit set");
    AST_CONT_CLK: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ##1 clk_lane_hs_bypass == $past(ctrl_reg[7])) else $error("bypass stale");
    AST_TDM_SLOT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tdm_en && aud_src ##1 tdm_en |-> primary_audio_data_pin ==
        $past(audio_par_data[tdm_slot_reg])) else $error("tdm slot data wrong");
endmodule

// file: tb/test_bridge_status_config_regs.sv
`timescale 1ns/10ps
module test_bridge_status_config_regs;
    import bsc_pkg::*;
    // clock and reset
    logic        ref_clk;
    logic        sys_rst;
    // register port
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    // memory, video, audio
    logic        nvm_rd;
    logic [6:0]  nvm_addr;
    logic [7:0]  nvm_data;
    logic        pix_valid;
    logic [2:0]  pix_format;
    logic [23:0] pix_data;
    logic        pix_out_valid;
    logic [23:0] pix_out_data;
    logic [1:0]  bpp;
    logic [1:0]  bpp_p1;
    logic        hs_bypass;
    logic [3:0]  audio_par_data;
    logic        audio_pin;
    logic        audio_enable;
    logic        aux_audio_enable;
    logic        irq;
    logic [7:0]  nvm_mem [128];
    int          mismatches;
    int          n_checks;
    int          ones;

    assign nvm_data = nvm_mem[nvm_addr];

    bsc_regs DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .nvm_data(nvm_data),
        .pix_valid(pix_valid), .pix_format(pix_format), .pix_data(pix_data),
        .pix_out_valid(pix_out_valid), .pix_out_data(pix_out_data),
        .input_pixel_byte_count(bpp), .input_pixel_byte_count_port1(bpp_p1),
        .clk_lane_hs_bypass(hs_bypass), .audio_par_data(audio_par_data),
        .primary_audio_data_pin(audio_pin), .audio_enable(audio_enable),
        .aux_audio_enable(aux_audio_enable), .irq(irq));

    always #2 ref_clk = ~ref_clk;

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        reg_addr  <= addr;
        reg_wdata <= data;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic read_check(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= addr;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        check({16'h0000, reg_rdata}, {16'h0000, exp});
    endtask

    task automatic pix_check(input logic [2:0] fmt, input logic [23:0] data,
                             input logic [23:0] exp);
        @(posedge ref_clk);
        pix_valid  <= 1'b1;
        pix_format <= fmt;
        pix_data   <= data;
        @(posedge ref_clk);
        pix_valid  <= 1'b0;
        #1;
        check({23'h0, pix_out_valid}, 24'h000001);
        check(pix_out_data, exp);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #80000;
        mismatches++;
        complete_run();
    end

    initial begin
        ref_clk = 1'b0; sys_rst = 1'b1; reg_addr = 8'h00; reg_wdata = 8'h00;
        reg_wr = 1'b0; reg_rd = 1'b0; pix_valid = 1'b0; pix_format = 3'h0;
        pix_data = 24'h000000; audio_par_data = 4'h1; mismatches = 0; n_checks = 0;
        foreach (nvm_mem[i]) nvm_mem[i] = 8'h00;
        nvm_mem[3] = 8'h5A;
        nvm_mem[9] = 8'hA6;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // auto load still running: only the checksum reset value shows
        read_check(BSC_ADDR_STATUS, 8'h02);
        read_check(BSC_ADDR_CONFIG, 8'h02);
        tick(200);
        read_check(BSC_ADDR_STATUS, 8'h16);
        check({23'h0, nvm_rd}, 24'h0);
        check({22'h0, audio_enable, aux_audio_enable}, 24'h2);
        // status is read only, reserved bits stay zero, unmapped reads zero
        reg_write(BSC_ADDR_STATUS, 8'hFF);
        read_check(BSC_ADDR_STATUS, 8'h16);
        read_check(8'h70, 8'h00);
        reg_write(BSC_ADDR_CONFIG, 8'hFF);
        read_check(BSC_ADDR_CONFIG, 8'h37);
        // every pixel size code, audio bits cleared and set
        for (int c = 0; c < 3; c++) begin
            reg_write(BSC_ADDR_CONFIG, {2'b00, c[1:0], 4'h0});
            read_check(BSC_ADDR_CONFIG, {2'b00, c[1:0], 4'h0});
            tick(2);
            check({22'h0, bpp}, {22'h0, c[1:0]});
            check({22'h0, bpp_p1}, {22'h0, c[1:0]});
            check({22'h0, audio_enable, aux_audio_enable}, 24'h0);
        end
        reg_write(BSC_ADDR_CONFIG, 8'h03);
        tick(2);
        check({22'h0, audio_enable, aux_audio_enable}, 24'h3);
        // tdm: one of four parallel lines high, so a quarter of slots carry one
        reg_write(BSC_ADDR_CONFIG, 8'h06);
        tick(2);
        ones = 0;
        repeat (8) begin
            tick(1);
            ones += int'(audio_pin === 1'b1);
        end
        check(ones[23:0], 24'h2);
        // continuous clock bypasses clock-lane start-up
        reg_write(BSC_ADDR_CTRL, 8'h80);
        tick(2);
        check({23'h0, hs_bypass}, 24'h1);
        // independent mode with port one selected gets its own size copy
        reg_write(BSC_ADDR_CONFIG, 8'h02);
        reg_write(BSC_ADDR_CTRL, 8'h21);
        reg_write(BSC_ADDR_CONFIG, 8'h22);
        read_check(BSC_ADDR_CONFIG, 8'h22);
        tick(2);
        check({20'h0, bpp, bpp_p1}, 24'h2);
        reg_write(BSC_ADDR_CTRL, 8'h01);
        read_check(BSC_ADDR_CONFIG, 8'h02);
        reg_write(BSC_ADDR_CTRL, 8'h00);
        // passthrough formats keep their bits
        pix_check(BSC_FMT_RGB888, 24'hA5C3E1, 24'hA5C3E1);
        pix_check(BSC_FMT_YCBCR, 24'h123456, 24'h123456);
        pix_check(BSC_FMT_COMP, 24'hFEDCBA, 24'hFEDCBA);
        // narrow rgb: full scale stays full scale, zero stays zero
        pix_check(BSC_FMT_RGB565, 24'h00F800, 24'hFF0000);
        pix_check(BSC_FMT_RGB666P, 24'h03FFFF, 24'hFFFFFF);
        pix_check(BSC_FMT_RGB666L, 24'h000000, 24'h000000);
        // interrupt: done events pending; mask hides them; clear drops them
        read_check(BSC_ADDR_IRQ_ST, 8'h03);
        reg_write(BSC_ADDR_IRQ_MK, 8'h00);
        tick(2);
        check({23'h0, irq}, 24'h1);
        reg_write(BSC_ADDR_IRQ_MK, 8'h07);
        tick(2);
        check({23'h0, irq}, 24'h0);
        reg_write(BSC_ADDR_IRQ_MK, 8'h00);
        reg_write(BSC_ADDR_IRQ_ST, 8'h03);
        tick(2);
        check({23'h0, irq}, 24'h0);
        read_check(BSC_ADDR_IRQ_ST, 8'h00);
        // reload with a corrupted memory image: checksum fails
        nvm_mem[40] = 8'h01;
        reg_write(BSC_ADDR_CTRL, 8'h02);
        read_check(BSC_ADDR_CTRL, 8'h02);
        check({23'h0, nvm_rd}, 24'h1);
        check({17'h0, nvm_addr}, 24'h2);
        tick(200);
        read_check(BSC_ADDR_CTRL, 8'h00);
        read_check(BSC_ADDR_STATUS, 8'h14);
        read_check(BSC_ADDR_IRQ_ST, 8'h07);
        check({23'h0, irq}, 24'h1);
        complete_run();
    end
endmodule
